/* hdl/atq_top.sv */
// alarm relay contact mapping and over-torque monitor with register port
// Contract
// RULE_01 - default polarity, normal: common-first closed, common-second open
// RULE_02 - normal means powered and in run or stop; else abnormal
// RULE_03 - default polarity, trip or power loss: both paths swap
// RULE_04 - inverted polarity: reversed in normal and trip; power off first open
// RULE_05 - flag rises when torque exceeds threshold of present quadrant
// RULE_06 - flag falls while torque stays below quadrant threshold
// RULE_07 - four quadrant thresholds, each 0 to 200 percent
// RULE_08 - flag routed to terminals or relay whose selector holds code 07
// RULE_09 - flag valid only with vector control method codes 03, 04, 05
// RULE_10 - monitor only observes torque; never limits it
// RULE_11 - alarm-assigned terminal on from alarm until cleared, off otherwise
`timescale 1ns/10ps
`default_nettype none
module atq_top
	import atq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic power_good,
	input wire atq_pkg::atq_run_t run_state,
	input wire logic alarm_clear,
	input wire logic [atq_pkg::ATQ_TQ_W-1:0] torque_est,
	input wire logic torque_reverse,
	input wire logic torque_regen,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic relay_first_closed,
	output logic relay_second_closed,
	output logic [atq_pkg::ATQ_NUM_TERM-1:0] term_out,
	output logic irq
);
	import atq_pkg::*;

	// ****************************************
	// configuration registers and internal signals
	// ****************************************
	logic [7:0] relay_polarity_select;
	logic [7:0] control_method_select;
	logic [7:0] fwd_drive_torque_threshold;
	logic [7:0] rev_regen_torque_threshold;
	logic [7:0] rev_drive_torque_threshold;
	logic [7:0] fwd_regen_torque_threshold;
	logic [7:0] output_terminal_function_select [ATQ_NUM_TERM];
	logic [7:0] relay_func_select;
	logic [ATQ_IRQ_W-1:0] irq_status;
	logic [ATQ_IRQ_W-1:0] irq_mask;
	logic torque_excess_flag;
	logic fault_flag_output;
	logic normal_state;
	logic [7:0] next_thr;
	logic vector_mode;
	logic [ATQ_IRQ_W-1:0] events;
	logic [ATQ_IRQ_W-1:0] prev_levels;
	logic [ATQ_IRQ_W-1:0] levels;
	logic [7:0] thr_clamped;
	logic wr_polarity;
	logic wr_method;
	logic wr_thr_fd;
	logic wr_thr_rr;
	logic wr_thr_rd;
	logic wr_thr_fr;
	logic wr_relay_func;
	logic wr_irq_mask;
	logic wr_irq_stat;
	logic next_first_closed;
	logic next_second_closed;

	// ****************************************
	// write decode
	// ****************************************
	assign wr_polarity = reg_wr && (reg_addr == ATQ_REG_POLARITY);
	assign wr_method = reg_wr && (reg_addr == ATQ_REG_METHOD);
	assign wr_thr_fd = reg_wr && (reg_addr == ATQ_REG_THR_FD);
	assign wr_thr_rr = reg_wr && (reg_addr == ATQ_REG_THR_RR);
	assign wr_thr_rd = reg_wr && (reg_addr == ATQ_REG_THR_RD);
	assign wr_thr_fr = reg_wr && (reg_addr == ATQ_REG_THR_FR);
	assign wr_relay_func = reg_wr && (reg_addr == ATQ_REG_FUNC_RELAY);
	assign wr_irq_mask = reg_wr && (reg_addr == ATQ_REG_IRQ_MASK);
	assign wr_irq_stat = reg_wr && (reg_addr == ATQ_REG_IRQ_STAT);

	// values above range are clamped to the top of range
	assign thr_clamped = (reg_wdata > ATQ_THR_MAX) ? ATQ_THR_MAX : reg_wdata; // RULE_07

	// ****************************************
	// relay, method and interrupt mask configuration
	// ****************************************
	// one block per register keeps each reset value beside its write
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			relay_polarity_select <= ATQ_POL_DEFAULT;
		end else if (wr_polarity) begin
			relay_polarity_select <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			control_method_select <= ATQ_METHOD_RESET;
		end else if (wr_method) begin
			control_method_select <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			relay_func_select <= ATQ_RELAY_FUNC_RESET;
		end else if (wr_relay_func) begin
			relay_func_select <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_mask <= '0;
		end else if (wr_irq_mask) begin
			irq_mask <= reg_wdata[ATQ_IRQ_W-1:0];
		end
	end

	// ****************************************
	// quadrant thresholds
	// ****************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fwd_drive_torque_threshold <= ATQ_THR_RESET;
		end else if (wr_thr_fd) begin
			fwd_drive_torque_threshold <= thr_clamped; // RULE_07
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rev_regen_torque_threshold <= ATQ_THR_RESET;
		end else if (wr_thr_rr) begin
			rev_regen_torque_threshold <= thr_clamped; // RULE_07
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rev_drive_torque_threshold <= ATQ_THR_RESET;
		end else if (wr_thr_rd) begin
			rev_drive_torque_threshold <= thr_clamped; // RULE_07
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fwd_regen_torque_threshold <= ATQ_THR_RESET;
		end else if (wr_thr_fr) begin
			fwd_regen_torque_threshold <= thr_clamped; // RULE_07
		end
	end

	// ****************************************
	// terminal selectors
	// ****************************************
	// terminal selectors live at consecutive addresses
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < ATQ_NUM_TERM; i++) begin
				output_terminal_function_select[i] <= ATQ_FUNC_RESET;
			end
		end else if (reg_wr) begin
			for (int i = 0; i < ATQ_NUM_TERM; i++) begin
				if (reg_addr == ATQ_REG_FUNC0 + 4'(i)) begin
					output_terminal_function_select[i] <= reg_wdata;
				end
			end
		end
	end

	// ****************************************
	// over-torque monitor
	// ****************************************
	always_comb begin
		unique case ({torque_reverse, torque_regen})
			2'b00: next_thr = fwd_drive_torque_threshold;
			2'b01: next_thr = fwd_regen_torque_threshold;
			2'b10: next_thr = rev_drive_torque_threshold;
			default: next_thr = rev_regen_torque_threshold;
		endcase
	end

	// ****************************************
	// vector mode gate
	// ****************************************
	assign vector_mode = (control_method_select == ATQ_CM_SLV) ||
		(control_method_select == ATQ_CM_SLV0) ||
		(control_method_select == ATQ_CM_VEC); // RULE_09

	// ****************************************
	// torque flag
	// ****************************************
	// observe only: nothing here feeds back into torque control
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			torque_excess_flag <= 1'b0;
		end else if (!vector_mode) begin
			torque_excess_flag <= 1'b0; // RULE_09
		end else if (torque_est > {1'b0, next_thr}) begin
			torque_excess_flag <= 1'b1; // RULE_05 RULE_10
		end else begin
			torque_excess_flag <= 1'b0; // RULE_06
		end
	end

	// ****************************************
	// alarm latch and relay
	// ****************************************
	assign normal_state = power_good && (run_state != ATQ_RUN_TRIP); // RULE_02

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fault_flag_output <= 1'b0;
		end else if (run_state == ATQ_RUN_TRIP) begin
			fault_flag_output <= 1'b1; // RULE_11
		end else if (alarm_clear) begin
			fault_flag_output <= 1'b0; // RULE_11
		end
	end

	// ****************************************
	// relay contacts
	// ****************************************
	// torque function ignores polarity: the flag alone drives the contact
	always_comb begin
		if (relay_func_select == ATQ_FN_TORQUE) begin
			next_first_closed = torque_excess_flag; // RULE_08
			next_second_closed = !torque_excess_flag; // RULE_08
		end else if (!power_good) begin
			next_first_closed = 1'b0; // RULE_03 RULE_04
			next_second_closed = 1'b1; // RULE_03 RULE_04
		end else if (relay_polarity_select == ATQ_POL_INVERTED) begin
			next_first_closed = !normal_state; // RULE_04
			next_second_closed = normal_state; // RULE_04
		end else begin
			next_first_closed = normal_state; // RULE_01 RULE_03
			next_second_closed = !normal_state; // RULE_01 RULE_03
		end
	end

	// reset state shows the unpowered contact position
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			relay_first_closed <= 1'b0;
			relay_second_closed <= 1'b1;
		end else begin
			relay_first_closed <= next_first_closed;
			relay_second_closed <= next_second_closed;
		end
	end

	// ****************************************
	// output terminals
	// ****************************************
	for (genvar g = 0; g < ATQ_NUM_TERM; g++) begin : g_term
		atq_term_out u_term (
			.ref_clk(ref_clk),
			.rstn(rstn),
			.func_sel(output_terminal_function_select[g]),
			.torque_excess_flag(torque_excess_flag),
			.fault_flag_output(fault_flag_output),
			.term_on(term_out[g])
		);
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign levels = {!power_good, fault_flag_output, torque_excess_flag};
	assign events = levels & ~prev_levels;

	// ****************************************
	// edge detection
	// ****************************************
	// resets low, the idle level of every source, so no false event
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prev_levels <= '0;
		end else begin
			prev_levels <= levels;
		end
	end

	// ****************************************
	// irq status
	// ****************************************
	// set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= '0;
		end else if (wr_irq_stat) begin
			irq_status <= (irq_status & ~reg_wdata[ATQ_IRQ_W-1:0]) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// ****************************************
	// irq output
	// ****************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ATQ_REG_POLARITY: reg_rdata <= relay_polarity_select;
				ATQ_REG_METHOD: reg_rdata <= control_method_select;
				ATQ_REG_THR_FD: reg_rdata <= fwd_drive_torque_threshold;
				ATQ_REG_THR_RR: reg_rdata <= rev_regen_torque_threshold;
				ATQ_REG_THR_RD: reg_rdata <= rev_drive_torque_threshold;
				ATQ_REG_THR_FR: reg_rdata <= fwd_regen_torque_threshold;
				ATQ_REG_FUNC_RELAY: reg_rdata <= relay_func_select;
				ATQ_REG_STATUS: reg_rdata <= {5'h00, levels};
				ATQ_REG_IRQ_STAT: reg_rdata <= {5'h00, irq_status};
				ATQ_REG_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
				default: begin
					if (reg_addr >= ATQ_REG_FUNC0 && reg_addr < ATQ_REG_FUNC_RELAY) begin
						reg_rdata <= output_terminal_function_select[3'(reg_addr - ATQ_REG_FUNC0)];
					end else begin
						reg_rdata <= 8'h00;
					end
				end
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

/* hdl/atq_pkg.sv */
// shared constants for the alarm relay and over-torque output block
package atq_pkg;
	// relay polarity codes
	localparam logic [7:0] ATQ_POL_INVERTED = 8'h00;
	localparam logic [7:0] ATQ_POL_DEFAULT = 8'h01;
	// output terminal function codes
	localparam logic [7:0] ATQ_FN_FAULT = 8'h05;
	localparam logic [7:0] ATQ_FN_TORQUE = 8'h07;
	// control method codes for the vector modes
	localparam logic [7:0] ATQ_CM_SLV = 8'h03;
	localparam logic [7:0] ATQ_CM_SLV0 = 8'h04;
	localparam logic [7:0] ATQ_CM_VEC = 8'h05;
	// threshold range in percent
	localparam logic [7:0] ATQ_THR_MAX = 8'hC8;
	localparam logic [7:0] ATQ_THR_RESET = 8'hC8;
	localparam int ATQ_NUM_TERM = 5;
	localparam int ATQ_TQ_W = 9;
	// register map, word addresses
	localparam logic [3:0] ATQ_REG_POLARITY = 4'h0;
	localparam logic [3:0] ATQ_REG_METHOD = 4'h1;
	localparam logic [3:0] ATQ_REG_THR_FD = 4'h2;
	localparam logic [3:0] ATQ_REG_THR_RR = 4'h3;
	localparam logic [3:0] ATQ_REG_THR_RD = 4'h4;
	localparam logic [3:0] ATQ_REG_THR_FR = 4'h5;
	localparam logic [3:0] ATQ_REG_FUNC0 = 4'h6;
	localparam logic [3:0] ATQ_REG_FUNC_RELAY = 4'hB;
	localparam logic [3:0] ATQ_REG_STATUS = 4'hC;
	localparam logic [3:0] ATQ_REG_IRQ_STAT = 4'hD;
	localparam logic [3:0] ATQ_REG_IRQ_MASK = 4'hE;
	localparam logic [7:0] ATQ_FUNC_RESET = 8'h00;
	localparam logic [7:0] ATQ_RELAY_FUNC_RESET = 8'h05;
	localparam logic [7:0] ATQ_METHOD_RESET = 8'h00;
	// status/interrupt bit positions
	localparam int ATQ_BIT_TORQUE = 0;
	localparam int ATQ_BIT_FAULT = 1;
	localparam int ATQ_BIT_POWER = 2;
	localparam int ATQ_IRQ_W = 3;
	// run state encoding from the drive core
	typedef enum logic [1:0] {
		ATQ_RUN_STOP = 2'b00,
		ATQ_RUN_RUN = 2'b01,
		ATQ_RUN_TRIP = 2'b11
	} atq_run_t;
endpackage

/* hdl/atq_term_out.sv */
// one programmable output terminal with its function selector
`timescale 1ns/10ps
`default_nettype none
module atq_term_out
	import atq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] func_sel,
	input wire logic torque_excess_flag,
	input wire logic fault_flag_output,
	output logic term_on
);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			term_on <= 1'b0;
		end else begin
			unique case (func_sel)
				ATQ_FN_TORQUE: term_on <= torque_excess_flag; // RULE_08
				ATQ_FN_FAULT: term_on <= fault_flag_output; // RULE_11
				default: term_on <= 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

/* bench/atq_top_asserts.sv */
// checker for relay mapping, torque flag and register port
`timescale 1ns/10ps
`default_nettype none
module atq_chk
	import atq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic power_good,
	input wire atq_pkg::atq_run_t run_state,
	input wire logic [atq_pkg::ATQ_TQ_W-1:0] torque_est,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic relay_first_closed,
	input wire logic relay_second_closed,
	input wire logic irq
);
	import atq_pkg::*;
	// shadow copies, so each property knows the live configuration
	logic pol_inv, method_ok, relay_t, mask_zero;
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) pol_inv <= 1'b0;
		else if (reg_wr && reg_addr == ATQ_REG_POLARITY) pol_inv <= reg_wdata == ATQ_POL_INVERTED;
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) method_ok <= 1'b0;
		else if (reg_wr && reg_addr == ATQ_REG_METHOD) method_ok <= reg_wdata inside {8'h03, 8'h04, 8'h05};
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) relay_t <= 1'b0;
		else if (reg_wr && reg_addr == ATQ_REG_FUNC_RELAY) relay_t <= reg_wdata == ATQ_FN_TORQUE;
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) mask_zero <= 1'b1;
		else if (reg_wr && reg_addr == ATQ_REG_IRQ_MASK) mask_zero <= reg_wdata[2:0] == 3'h0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	rel_compl_a: assert property (relay_first_closed != relay_second_closed)
		else $error("relay paths equal");
	pwr_off_a: assert property (!power_good && !relay_t |=> !relay_first_closed)
		else $error("first path closed without power");
	trip_map_a: assert property (power_good && run_state == ATQ_RUN_TRIP && !relay_t |=> relay_first_closed == pol_inv)
		else $error("trip contact state wrong");
	rd_idle_a: assert property (!reg_rd || reg_addr == 4'hF |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	tq_method_a: assert property ((relay_t && !method_ok) [*3] |-> !relay_first_closed)
		else $error("torque flag outside vector modes");
	tq_zero_a: assert property ((relay_t && torque_est == 9'h000) [*3] |-> !relay_first_closed)
		else $error("torque flag at zero torque");
	tq_over_a: assert property ((relay_t && method_ok && torque_est > 9'h0C8) [*3] |-> relay_first_closed)
		else $error("torque flag missing above limit");
	irq_mask_a: assert property (mask_zero [*2] |-> !irq)
		else $error("irq with empty mask");
	trip_c: cover property (power_good && run_state == ATQ_RUN_TRIP);
	tq_c: cover property (relay_t && relay_first_closed);
	irq_c: cover property (irq);
endmodule
bind atq_top atq_chk i_chk (.ref_clk, .rstn, .power_good, .run_state, .torque_est, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .relay_first_closed, .relay_second_closed, .irq);
`default_nettype wire

/* bench/atq_load_model.sv */
// far-side controller: reads terminals and contacts, issues alarm reset
`timescale 1ns/10ps
`default_nettype none
module atq_load_model (
	input wire logic ref_clk,
	input wire logic [4:0] term_out,
	input wire logic relay_first_closed,
	input wire logic relay_second_closed,
	input wire logic clr_req,
	output logic alarm_clear,
	output logic [4:0] seen_term,
	output logic [1:0] seen_relay
);
	// registered view, as a real controller samples its inputs
	always @(posedge ref_clk) begin
		alarm_clear <= clr_req;
		seen_term <= term_out;
		seen_relay <= {relay_first_closed, relay_second_closed};
	end
endmodule
`default_nettype wire

/* bench/atq_top_tb_top.sv */
// testbench for the relay and over-torque block
`timescale 1ns/10ps
`default_nettype none
module atq_top_tb_top;
	import atq_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0, power_good = 1'b1, torque_reverse = 1'b0, torque_regen = 1'b0;
	atq_run_t run_state = ATQ_RUN_STOP;
	logic [8:0] torque_est = 9'h000;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
	logic reg_wr = 1'b0, reg_rd = 1'b0, clr_req = 1'b0, alarm_clear, relay_first_closed, relay_second_closed, irq;
	logic [4:0] term_out, seen_term;
	logic [1:0] seen_relay;
	int miscompares = 0, checked = 0, cycles = 0;
	atq_top i_dut (.ref_clk, .rstn, .power_good, .run_state, .alarm_clear, .torque_est, .torque_reverse,
		.torque_regen, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .relay_first_closed,
		.relay_second_closed, .term_out, .irq);
	atq_load_model i_load (.ref_clk, .term_out, .relay_first_closed, .relay_second_closed, .clr_req,
		.alarm_clear, .seen_term, .seen_relay);
	initial forever #10 ref_clk = ~ref_clk;
	// a hang would otherwise never reach the verdict
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			final_report;
		end
	end
	task automatic final_report;
		if (miscompares == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		rd_val = reg_rdata;
	endtask
	// settle ends on a falling edge so outputs are sampled away from updates
	task automatic settle;
		repeat (5) @(negedge ref_clk);
	endtask
	task automatic clear_alarm;
		@(posedge ref_clk);
		clr_req <= 1'b1;
		repeat (3) @(posedge ref_clk);
		clr_req <= 1'b0;
	endtask
	task automatic t_reset_values;
		for (int i = 0; i < 7; i++) begin
			rd(i < 6 ? 4'(i) : ATQ_REG_FUNC_RELAY);
			check("reg reset", rd_val, i == 0 ? 8'h01 : i == 1 ? 8'h00 : i == 6 ? 8'h05 : ATQ_THR_RESET);
		end
		rd(4'hF);
		check("unmapped read", rd_val, 8'h00);
		check("relay stop", seen_relay, 2'b10);
	endtask
	task automatic t_relay_map;
		for (int i = 0; i < 6; i++) begin
			if (i % 3 == 0) wr(ATQ_REG_POLARITY, i < 3 ? ATQ_POL_DEFAULT : ATQ_POL_INVERTED);
			@(posedge ref_clk);
			power_good <= i % 3 != 2;
			run_state <= i % 3 == 1 ? ATQ_RUN_TRIP : ATQ_RUN_RUN;
			clear_alarm;
			settle;
			check("relay paths", seen_relay, i % 3 == 2 || ((i % 3 == 1) ^ (i >= 3)) ? 2'b01 : 2'b10);
		end
		wr(ATQ_REG_POLARITY, ATQ_POL_DEFAULT);
		@(posedge ref_clk);
		power_good <= 1'b1;
		run_state <= ATQ_RUN_STOP;
		clear_alarm;
	endtask
	task automatic t_torque;
		logic [7:0] thr;
		wr(ATQ_REG_THR_FD, 8'hFF);
		rd(ATQ_REG_THR_FD);
		check("threshold clamp", rd_val, ATQ_THR_MAX);
		wr(ATQ_REG_FUNC_RELAY, ATQ_FN_TORQUE);
		@(posedge ref_clk);
		torque_est <= 9'h0C9;
		settle;
		check("relay method off", seen_relay, 2'b01);
		wr(ATQ_REG_METHOD, ATQ_CM_VEC);
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			torque_est <= k == 0 ? 9'h0C9 : 9'h000;
			settle;
			check("relay torque", seen_relay, k == 0 ? 2'b10 : 2'b01);
		end
		wr(ATQ_REG_FUNC_RELAY, ATQ_FN_FAULT);
		wr(ATQ_REG_THR_FD, 8'h10);
		wr(ATQ_REG_THR_RR, 8'h20);
		wr(ATQ_REG_THR_RD, 8'h30);
		wr(ATQ_REG_THR_FR, 8'h40);
		wr(ATQ_REG_FUNC0, ATQ_FN_TORQUE);
		wr(ATQ_REG_FUNC0 + 4'h4, ATQ_FN_TORQUE);
		rd(ATQ_REG_FUNC0 + 4'h4);
		check("terminal select", rd_val, ATQ_FN_TORQUE);
		for (int m = 0; m < 4; m++) begin
			wr(ATQ_REG_METHOD, m == 3 ? 8'h00 : ATQ_CM_SLV + 8'(m));
			for (int q = 0; q < 8; q++) begin
				thr = q[2:1] == 0 ? 8'h10 : q[2:1] == 1 ? 8'h40 : q[2:1] == 2 ? 8'h30 : 8'h20;
				@(posedge ref_clk);
				{torque_reverse, torque_regen} <= q[2:1];
				torque_est <= {1'b0, thr} + 9'(q[0]);
				settle;
				check("torque flag", seen_term[0], q[0] && m < 3);
				check("torque flag last", seen_term[4], q[0] && m < 3);
			end
		end
	endtask
	task automatic t_fault_irq;
		wr(ATQ_REG_FUNC0 + 4'h1, ATQ_FN_FAULT);
		wr(ATQ_REG_IRQ_STAT, 8'h07);
		@(posedge ref_clk);
		run_state <= ATQ_RUN_TRIP;
		settle;
		check("irq masked", irq, 1'b0);
		rd(ATQ_REG_STATUS);
		check("status levels", rd_val, 8'h02);
		@(posedge ref_clk);
		run_state <= ATQ_RUN_STOP;
		settle;
		check("fault held", seen_term[1], 1'b1);
		check("unused terminals", seen_term[3:2], 2'b00);
		wr(ATQ_REG_IRQ_MASK, 8'h02);
		settle;
		check("irq raised", irq, 1'b1);
		rd(ATQ_REG_IRQ_STAT);
		check("irq status", rd_val, 8'h02);
		clear_alarm;
		settle;
		check("fault cleared", seen_term[1], 1'b0);
		wr(ATQ_REG_IRQ_STAT, 8'h02);
		settle;
		check("irq cleared", irq, 1'b0);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset_values;
		t_relay_map;
		t_torque;
		t_fault_irq;
		final_report;
	end
endmodule
`default_nettype wire
